// File: rtl/msctl_defines.svh
// Constants for the mode/supply and hardware control register bank.
// Assumes inclusion by bare name from rtl files.
`ifndef MSCTL_DEFINES_SVH
`define MSCTL_DEFINES_SVH
// ==========================================
// Frame layout
`define MSCTL_FRAME_W 16
`define MSCTL_ADDR_W 7
`define MSCTL_RW_BIT 7
`define MSCTL_DATA_LSB 8
// ==========================================
// Register offsets
`define MSCTL_ADDR_MODE_SUPPLY 7'h01
`define MSCTL_ADDR_HARDWARE_CONTROL 7'h02
// ==========================================
// Reset and restart patterns
`define MSCTL_MODE_SUPPLY_POR 8'h00
`define MSCTL_HARDWARE_CONTROL_POR 8'h00
`define MSCTL_MODE_SUPPLY_RST_KEEP 8'h07
`define MSCTL_HARDWARE_CONTROL_RST_KEEP 8'hdf
`define MSCTL_MODE_SUPPLY_RST_VAL 8'h00
`define MSCTL_HARDWARE_CONTROL_RST_VAL 8'h00
// ==========================================
// Field positions
`define MSCTL_MODE_HI 7
`define MSCTL_MODE_LO 6
`define MSCTL_RSVD_BIT 5
`define MSCTL_AUX_HI 4
`define MSCTL_AUX_LO 3
`define MSCTL_OVR_BIT 2
`define MSCTL_THR_HI 1
`define MSCTL_THR_LO 0
`define MSCTL_FSI_BIT 7
`define MSCTL_TLAG_BIT 6
`define MSCTL_FORCE_BIT 5
`define MSCTL_BYWK_BIT 4
`define MSCTL_AUTO_BIT 3
`define MSCTL_BLOW_BIT 2
`define MSCTL_BEN_BIT 1
`define MSCTL_CFG_BIT 0
// ==========================================
// Timing
`define MSCTL_TLAG_SHORT_US 100
`define MSCTL_TLAG_LONG_US 1000
`define MSCTL_CLK_MHZ 100
`endif

// File: rtl/msctl_pkg.sv
// Types for the mode/supply and hardware control register bank.
// Assumes nothing beyond the defines header.
`default_nettype none
package msctl_pkg;
  // ==========================================
  // Operating mode and auxiliary supply mode codes
  typedef enum logic [1:0] {
    MSCTL_NORMAL = 2'h0,
    MSCTL_SLEEP = 2'h1,
    MSCTL_STOP = 2'h2,
    MSCTL_SOFTRST = 2'h3
  } msctl_mode_t;
  typedef enum logic [1:0] {
    MSCTL_AUX_OFF = 2'h0,
    MSCTL_AUX_NORMAL = 2'h1,
    MSCTL_AUX_STOP = 2'h2,
    MSCTL_AUX_ALL = 2'h3
  } msctl_aux_t;
endpackage
`default_nettype wire

// File: rtl/msctl_regs.sv
// Mode/supply and hardware control register bank with a 16-bit frame port.
// Assumes frames arrive already deserialised and synchronous to clk.
//
// Summary of operation
// - Frame is 16 bits: address seven bits, access bit, then data byte.
// - Access bit 0 reads only; 1 writes the data byte; one byte always.
// - Register data bits 0..7 sit in frame bits 8..15.
// - Power-on or soft reset loads every register with its power-on value.
// - Restart loads restart pattern; don't-care bits keep their value.
// - Hardware-updatable bits also change by hardware; read-only bits ignore writes.
// - Mode field 7:6 selects normal, sleep or stop.
// - Mode code 11 runs a soft reset without the reset output.
// - Bit 5 of mode/supply is reserved and reads zero.
// - Auxiliary supply field 4:3 selects off, normal, normal+stop, all modes.
// - Bit 2 set makes main overvoltage trigger reset and restart.
// - Threshold field 1:0 selects level one, two, three, or disables reset.
// - Sleep request with no wake source enters restart with reset.
// - Hardware bit 7 keeps failsafe input, or turns pin into second fail output.
// - Bit 6 picks PWM to PFM lag: 100 us or 1 ms.
// - Bit 5 forces fail outputs on; clear means failure driven only.
// - Bit 4 lets wake pin choose PFM or PWM in stop.
// - Bit 3 auto moves PFM to PWM under load; stop command returns PFM.
// - Bit 2 selects fixed low boost level, else high-level bit decides.
// - Bit 1 enables boost, which turns on when battery is low.
// - Bit 0 fail outputs after first trigger fail if set, else second.
`include "msctl_defines.svh"
`default_nettype none
module msctl_regs
  import msctl_pkg::*;
#(
  parameter int TLAG_SHORT_CYC = `MSCTL_TLAG_SHORT_US * `MSCTL_CLK_MHZ,
  parameter int TLAG_LONG_CYC = `MSCTL_TLAG_LONG_US * `MSCTL_CLK_MHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Frame port
  input wire logic frame_valid,
  input wire logic [15:0] frame_in,
  output logic [7:0] read_data,
  // Device events
  input wire logic restart_req,
  input wire logic wake_source_any,
  input wire logic main_ov_event,
  input wire logic wdt_fail_event,
  input wire logic wake_pin,
  input wire logic heavy_load,
  input wire logic battery_low,
  // Mode and supply controls
  output logic [1:0] op_mode,
  output logic [1:0] aux_supply_mode,
  output logic main_supply_ov_reset_en,
  output logic [1:0] main_supply_reset_threshold,
  output logic undervoltage_reset_en,
  output logic soft_reset_pulse,
  output logic restart_enter,
  output logic reset_output,
  output logic aux_supply_on,
  // Hardware controls
  output logic failsafe_in_or_out_sel,
  output logic pwm_to_pfm_delay,
  output logic [16:0] pwm_lag_cycles,
  output logic fail_out_force,
  output logic pwm_select_by_wake_pin,
  output logic pwm_auto,
  output logic step_up_low_sel,
  output logic step_up_enable,
  output logic step_up_run,
  output logic fail_out_trigger_config,
  output logic fail_outputs,
  output logic failsafe_input_active,
  output logic buck_pwm
);
  // ==========================================
  // Synchronise pins
  logic wake_s1_q, wake_s2_q, load_s1_q, load_s2_q, bat_s1_q, bat_s2_q;
  always_ff @(posedge clk) begin
    wake_s1_q <= wake_pin;
    wake_s2_q <= wake_s1_q;
    load_s1_q <= heavy_load;
    load_s2_q <= load_s1_q;
    bat_s1_q <= battery_low;
    bat_s2_q <= bat_s1_q;
  end

  // ==========================================
  // Frame decode
  wire [6:0] f_addr = frame_in[`MSCTL_ADDR_W-1:0];
  wire f_write = frame_in[`MSCTL_RW_BIT];
  wire [7:0] f_data = frame_in[`MSCTL_FRAME_W-1:`MSCTL_DATA_LSB];
  wire wr_ms = frame_valid && f_write && (f_addr == `MSCTL_ADDR_MODE_SUPPLY);
  wire wr_hw = frame_valid && f_write && (f_addr == `MSCTL_ADDR_HARDWARE_CONTROL);
  wire soft_req = wr_ms && (f_data[7:6] == MSCTL_SOFTRST);
  wire sleep_bad = wr_ms && (f_data[7:6] == MSCTL_SLEEP) && !wake_source_any;
  wire stop_cmd = wr_ms && (f_data[7:6] == MSCTL_STOP);

  // ==========================================
  // Register state
  logic [7:0] ms_q, ms_d, hw_q, hw_d;
  logic soft_q, restart_q, fail_cnt_q, fo_fail_q, pwm_auto_act_q;

  // Restart trigger from outside, overvoltage or bad sleep
  wire ov_rst = main_ov_event && ms_q[`MSCTL_OVR_BIT];
  wire restart_now = restart_req || ov_rst || sleep_bad;

  // Next value of mode/supply register
  always_comb begin
    ms_d = ms_q;
    if (restart_now) begin
      ms_d = (ms_q & `MSCTL_MODE_SUPPLY_RST_KEEP) | `MSCTL_MODE_SUPPLY_RST_VAL;
    end else if (wr_ms && !soft_req) begin
      ms_d = f_data;
    end
    ms_d[`MSCTL_RSVD_BIT] = 1'b0;
  end

  // Next value of hardware control register
  always_comb begin
    hw_d = hw_q;
    if (restart_now) begin
      hw_d = (hw_q & `MSCTL_HARDWARE_CONTROL_RST_KEEP) | `MSCTL_HARDWARE_CONTROL_RST_VAL;
    end else if (wr_hw) begin
      hw_d = f_data;
    end
  end

  // Register update, power-on and soft reset
  always_ff @(posedge clk) begin
    if (sys_rst || soft_q) begin
      ms_q <= `MSCTL_MODE_SUPPLY_POR;
      hw_q <= `MSCTL_HARDWARE_CONTROL_POR;
    end else begin
      ms_q <= ms_d;
      hw_q <= hw_d;
    end
  end

  // Soft reset and restart pulses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      soft_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      soft_q <= soft_req;
      restart_q <= restart_now;
    end
  end

  // Watchdog failure counting for fail outputs
  always_ff @(posedge clk) begin
    if (sys_rst || soft_q) begin
      fail_cnt_q <= 1'b0;
      fo_fail_q <= 1'b0;
    end else if (wdt_fail_event) begin
      fail_cnt_q <= 1'b1;
      if (hw_q[`MSCTL_CFG_BIT] || fail_cnt_q) begin
        fo_fail_q <= 1'b1;
      end
    end
  end

  // Heavy load while auto PWM is on in stop mode
  wire auto_set = hw_q[`MSCTL_AUTO_BIT] && (ms_q[`MSCTL_MODE_HI:`MSCTL_MODE_LO] == MSCTL_STOP) && load_s2_q;

  // Automatic PWM latch; load still heavy beats a stop command
  always_ff @(posedge clk) begin
    if (sys_rst || soft_q) begin
      pwm_auto_act_q <= 1'b0;
    end else if (auto_set) begin
      pwm_auto_act_q <= 1'b1;
    end else if (stop_cmd) begin
      pwm_auto_act_q <= 1'b0;
    end
  end

  // Read data for the same frame
  logic [7:0] rd_q;
  wire [7:0] rd_sel = (f_addr == `MSCTL_ADDR_MODE_SUPPLY) ? ms_q :
                      (f_addr == `MSCTL_ADDR_HARDWARE_CONTROL) ? hw_q : 8'h00;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_q <= 8'h00;
    end else if (frame_valid) begin
      rd_q <= rd_sel;
    end
  end
  assign read_data = rd_q;

  // ==========================================
  // Mode/supply outputs
  wire in_stop = (ms_q[7:6] == MSCTL_STOP);
  wire in_sleep = (ms_q[7:6] == MSCTL_SLEEP);
  assign op_mode = ms_q[`MSCTL_MODE_HI:`MSCTL_MODE_LO];
  assign aux_supply_mode = ms_q[`MSCTL_AUX_HI:`MSCTL_AUX_LO];
  assign main_supply_ov_reset_en = ms_q[`MSCTL_OVR_BIT];
  assign main_supply_reset_threshold = ms_q[`MSCTL_THR_HI:`MSCTL_THR_LO];
  assign undervoltage_reset_en = (ms_q[1:0] != 2'h3);
  assign soft_reset_pulse = soft_q;
  assign restart_enter = restart_q;
  assign reset_output = restart_q;
  // Auxiliary supply on depending on current mode
  assign aux_supply_on = (aux_supply_mode == MSCTL_AUX_ALL) ||
                         (aux_supply_mode == MSCTL_AUX_STOP && !in_sleep) ||
                         (aux_supply_mode == MSCTL_AUX_NORMAL && !in_sleep && !in_stop);

  // ==========================================
  // Hardware control outputs
  assign failsafe_in_or_out_sel = hw_q[`MSCTL_FSI_BIT];
  assign failsafe_input_active = !hw_q[`MSCTL_FSI_BIT];
  assign pwm_to_pfm_delay = hw_q[`MSCTL_TLAG_BIT];
  assign pwm_lag_cycles = hw_q[`MSCTL_TLAG_BIT] ? 17'(TLAG_LONG_CYC) : 17'(TLAG_SHORT_CYC);
  assign fail_out_force = hw_q[`MSCTL_FORCE_BIT];
  assign fail_outputs = hw_q[`MSCTL_FORCE_BIT] || fo_fail_q;
  assign pwm_select_by_wake_pin = hw_q[`MSCTL_BYWK_BIT];
  assign pwm_auto = hw_q[`MSCTL_AUTO_BIT];

  // ==========================================
  // PWM to PFM lag
  logic buck_pwm_q;
  logic [16:0] lag_cnt_q;
  // Buck PWM request: normal mode, or wake pin or auto latch in stop
  wire buck_pwm_req = !in_stop ? !in_sleep :
                      (hw_q[`MSCTL_BYWK_BIT] && wake_s2_q) || pwm_auto_act_q;
  wire [16:0] lag_last = pwm_lag_cycles - 17'h00001;
  wire lag_done = (lag_cnt_q >= lag_last);

  // Keep PWM until the request has been low for the lag time
  always_ff @(posedge clk) begin
    if (sys_rst || buck_pwm_req) begin
      buck_pwm_q <= 1'b1;
      lag_cnt_q <= 17'h00000;
    end else if (buck_pwm_q && lag_done) begin
      buck_pwm_q <= 1'b0;
      lag_cnt_q <= 17'h00000;
    end else if (buck_pwm_q) begin
      lag_cnt_q <= lag_cnt_q + 17'h00001;
    end
  end
  assign buck_pwm = buck_pwm_q;
  assign step_up_low_sel = hw_q[`MSCTL_BLOW_BIT];
  assign step_up_enable = hw_q[`MSCTL_BEN_BIT];
  assign step_up_run = hw_q[`MSCTL_BEN_BIT] && bat_s2_q;
  assign fail_out_trigger_config = hw_q[`MSCTL_CFG_BIT];
endmodule
`default_nettype wire

// File: bench/msctl_host.sv
// Microcontroller model issuing 16-bit command frames.
// Assumes a free-running clk from the bench.
`default_nettype none
module msctl_host (
  // Clock
  input wire logic clk,
  // Frame side
  output logic frame_valid,
  output logic [15:0] frame_in,
  input wire logic [7:0] read_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Frame driver
  initial begin
    frame_valid = 1'b0;
    frame_in = 16'h0000;
  end
  // One frame, held one edge; idle bus shows inverted bits
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d, output logic [7:0] rd);
    @(posedge clk);
    #1;
    frame_valid = 1'b1;
    frame_in = {d, w, a};
    @(posedge clk);
    #1;
    rd = read_data;
    frame_valid = 1'b0;
    frame_in = ~frame_in;
  endtask
endmodule
`default_nettype wire

// File: bench/msctl_regs_chk.sv
// Port checker for the mode/supply and hardware control registers.
// Assumes binding into msctl_regs.
`default_nettype none
module msctl_regs_chk #(
  parameter int TLAG_SHORT_CYC = 10000,
  parameter int TLAG_LONG_CYC = 100000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Frame port and events
  input wire logic frame_valid,
  input wire logic [15:0] frame_in,
  input wire logic [7:0] read_data,
  input wire logic restart_req,
  input wire logic wake_source_any,
  input wire logic main_ov_event,
  // Controls
  input wire logic [1:0] op_mode,
  input wire logic main_supply_ov_reset_en,
  input wire logic [1:0] main_supply_reset_threshold,
  input wire logic undervoltage_reset_en,
  input wire logic soft_reset_pulse,
  input wire logic reset_output,
  input wire logic failsafe_in_or_out_sel,
  input wire logic pwm_to_pfm_delay,
  input wire logic fail_out_force,
  input wire logic pwm_select_by_wake_pin,
  input wire logic pwm_auto,
  input wire logic step_up_low_sel,
  input wire logic step_up_enable,
  input wire logic fail_out_trigger_config,
  input wire logic [16:0] pwm_lag_cycles,
  input wire logic failsafe_input_active
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Write decode
  wire [7:0] hw = {failsafe_in_or_out_sel, pwm_to_pfm_delay, fail_out_force, pwm_select_by_wake_pin,
    pwm_auto, step_up_low_sel, step_up_enable, fail_out_trigger_config};
  // No write lands while a soft reset clears the bank
  wire wr = frame_valid && frame_in[7] && !restart_req && !main_ov_event && !soft_reset_pulse;
  wire wr_ms = wr && frame_in[6:0] == 7'h01;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_HW_WRITE: assert property (wr && frame_in[6:0] == 7'h02 |=> hw == $past(frame_in[15:8]))
    else $error("hw write lost");
  AST_MODE_WRITE: assert property (wr_ms && frame_in[15:14] inside {2'h0, 2'h2} |=>
    op_mode == $past(frame_in[15:14]) && main_supply_reset_threshold == $past(frame_in[9:8])) else $error("mode");
  AST_RSVD_ZERO: assert property (frame_valid && frame_in[6:0] == 7'h01 |=> !read_data[5])
    else $error("reserved bit");
  AST_SOFT_RST: assert property (wr_ms && frame_in[15:14] == 2'h3 |=>
    soft_reset_pulse && !reset_output ##1 op_mode == 2'h0 && hw == 8'h00) else $error("soft reset");
  AST_RESTART: assert property (restart_req |=> reset_output && op_mode == 2'h0 && !fail_out_force)
    else $error("restart");
  AST_SLEEP_NOWAKE: assert property (wr_ms && frame_in[15:14] == 2'h1 && !wake_source_any |=>
    reset_output && op_mode != 2'h1) else $error("sleep");
  AST_OV_RESET: assert property (main_ov_event && main_supply_ov_reset_en |=> reset_output)
    else $error("ov reset");
  AST_UV_EN: assert property (undervoltage_reset_en == (main_supply_reset_threshold != 2'h3))
    else $error("uv enable");
  AST_FSI: assert property (failsafe_input_active != failsafe_in_or_out_sel)
    else $error("fsi");
  AST_LAG: assert property (pwm_lag_cycles == (pwm_to_pfm_delay ? TLAG_LONG_CYC : TLAG_SHORT_CYC))
    else $error("lag");
  cover property (wr_ms && frame_in[15:14] == 2'h3);
  cover property (restart_req);
  cover property (main_ov_event && main_supply_ov_reset_en);
endmodule
bind msctl_regs msctl_regs_chk #(.TLAG_SHORT_CYC(TLAG_SHORT_CYC), .TLAG_LONG_CYC(TLAG_LONG_CYC)) chk_i (
  .clk(clk),
  .sys_rst(sys_rst),
  .frame_valid(frame_valid),
  .frame_in(frame_in),
  .read_data(read_data),
  .restart_req(restart_req),
  .wake_source_any(wake_source_any),
  .main_ov_event(main_ov_event),
  .op_mode(op_mode),
  .main_supply_ov_reset_en(main_supply_ov_reset_en),
  .main_supply_reset_threshold(main_supply_reset_threshold),
  .undervoltage_reset_en(undervoltage_reset_en),
  .soft_reset_pulse(soft_reset_pulse),
  .reset_output(reset_output),
  .failsafe_in_or_out_sel(failsafe_in_or_out_sel),
  .pwm_to_pfm_delay(pwm_to_pfm_delay),
  .fail_out_force(fail_out_force),
  .pwm_select_by_wake_pin(pwm_select_by_wake_pin),
  .pwm_auto(pwm_auto),
  .step_up_low_sel(step_up_low_sel),
  .step_up_enable(step_up_enable),
  .fail_out_trigger_config(fail_out_trigger_config),
  .pwm_lag_cycles(pwm_lag_cycles),
  .failsafe_input_active(failsafe_input_active)
);
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the mode/supply and hardware control registers.
// Assumes host model and checker compiled first.
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, restart_req, wake_source_any, main_ov_event, battery_low, wake_pin, heavy_load, wdt_fail;
  wire frame_valid, uv_en, soft_p, rst_out, boost_run, fail_o, rst_enter, aux_on, buck;
  wire [15:0] frame_in;
  wire [7:0] read_data;
  wire [1:0] op_mode;
  wire [16:0] lag;
  logic [7:0] rd;
  int err_total, checked, i;
  // ==========================================
  // Design and host
  msctl_regs #(.TLAG_SHORT_CYC(10), .TLAG_LONG_CYC(100)) msctl_regs_i (.clk(clk), .sys_rst(sys_rst),
    .frame_valid(frame_valid), .frame_in(frame_in), .read_data(read_data), .restart_req(restart_req),
    .wake_source_any(wake_source_any), .main_ov_event(main_ov_event), .wdt_fail_event(wdt_fail), .wake_pin(wake_pin),
    .heavy_load(heavy_load), .battery_low(battery_low), .op_mode(op_mode), .aux_supply_mode(),
    .main_supply_ov_reset_en(), .main_supply_reset_threshold(), .undervoltage_reset_en(uv_en),
    .soft_reset_pulse(soft_p), .restart_enter(rst_enter), .reset_output(rst_out), .aux_supply_on(aux_on),
    .failsafe_in_or_out_sel(), .pwm_to_pfm_delay(), .pwm_lag_cycles(lag), .fail_out_force(),
    .pwm_select_by_wake_pin(), .pwm_auto(), .step_up_low_sel(), .step_up_enable(), .step_up_run(boost_run),
    .fail_out_trigger_config(), .fail_outputs(fail_o), .failsafe_input_active(), .buck_pwm(buck));
  msctl_host msctl_host_i (.clk(clk), .frame_valid(frame_valid), .frame_in(frame_in), .read_data(read_data));
  // Access tasks
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    msctl_host_i.xfer(a, 1'b1, d, rd);
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    msctl_host_i.xfer(a, 1'b0, 8'h00, rd);
    `CHK("read", e, rd)
  endtask
  // One-cycle event: 0 restart, 1 overvoltage, 2 watchdog fail
  task automatic evt(input logic [1:0] k);
    @(posedge clk);
    #1;
    restart_req = (k == 2'd0);
    main_ov_event = (k == 2'd1);
    wdt_fail = (k == 2'd2);
    @(posedge clk);
    #1;
    restart_req = 1'b0;
    main_ov_event = 1'b0;
    wdt_fail = 1'b0;
  endtask
  task automatic stop_test;
    $display("compared %0d mismatched %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    stop_test();
  end
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    restart_req = 1'b0;
    wake_source_any = 1'b1;
    main_ov_event = 1'b0;
    battery_low = 1'b0;
    wake_pin = 1'b0;
    heavy_load = 1'b0;
    wdt_fail = 1'b0;
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'b0;
    rchk(7'h01, 8'h00);
    rchk(7'h02, 8'h00);
    rchk(7'h03, 8'h00);
    `CHK("buck reset", 1'b1, buck)
    for (i = 0; i < 3; i++) begin
      wr(7'h01, {i[1:0], 6'h3f});
      `CHK("mode", i[1:0], op_mode)
    end
    `CHK("uv", 1'b0, uv_en)
    rchk(7'h01, 8'h9f);
    wr(7'h02, 8'ha5);
    `CHK("fail", 1'b1, fail_o)
    wr(7'h02, 8'h5a);
    `CHK("pre", 8'ha5, rd)
    `CHK("lag", 17'd100, lag)
    battery_low = 1'b1;
    repeat (3) @(posedge clk);
    `CHK("boost", 1'b1, boost_run)
    wr(7'h02, 8'hff);
    evt(2'd0);
    `CHK("restart", 1'b1, rst_out)
    `CHK("enter", 1'b1, rst_enter)
    rchk(7'h01, 8'h07);
    rchk(7'h02, 8'hdf);
    wr(7'h01, 8'h04);
    evt(2'd1);
    `CHK("ov", 1'b1, rst_out)
    wake_source_any = 1'b0;
    wr(7'h01, 8'h40);
    `CHK("sleep", 1'b1, rst_out)
    rchk(7'h01, 8'h04);
    wake_source_any = 1'b1;
    wr(7'h01, 8'h40);
    `CHK("mode", 2'h1, op_mode)
    wr(7'h01, 8'hc0);
    `CHK("soft", 1'b1, soft_p)
    `CHK("rstout", 1'b0, rst_out)
    rchk(7'h01, 8'h00);
    rchk(7'h02, 8'h00);
    // Wake pin selects PWM in stop, short lag back to PFM
    wr(7'h02, 8'h10);
    wake_pin = 1'b1;
    wr(7'h01, 8'h90);
    `CHK("aux stop", 1'b1, aux_on)
    `CHK("buck wake", 1'b1, buck)
    wake_pin = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    `CHK("lag short", 1'b1, buck)
    repeat (6) @(posedge clk);
    #1;
    `CHK("pfm wake", 1'b0, buck)
    // Auto PWM under load holds until a stop command, long lag
    wr(7'h02, 8'h48);
    heavy_load = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    `CHK("auto", 1'b1, buck)
    heavy_load = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("auto hold", 1'b1, buck)
    wr(7'h01, 8'h90);
    repeat (50) @(posedge clk);
    #1;
    `CHK("lag long", 1'b1, buck)
    repeat (60) @(posedge clk);
    #1;
    `CHK("pfm auto", 1'b0, buck)
    // Auxiliary supply against mode
    wr(7'h01, 8'h88);
    `CHK("aux normal only", 1'b0, aux_on)
    wr(7'h01, 8'h58);
    `CHK("aux all", 1'b1, aux_on)
    wr(7'h01, 8'h50);
    `CHK("aux sleep", 1'b0, aux_on)
    // Fail outputs after second or first watchdog fail
    evt(2'd2);
    `CHK("fo one fail", 1'b0, fail_o)
    evt(2'd2);
    `CHK("fo two fails", 1'b1, fail_o)
    wr(7'h01, 8'hc0);
    wr(7'h02, 8'h01);
    evt(2'd2);
    `CHK("fo cfg", 1'b1, fail_o)
    stop_test();
  end
endmodule
`default_nettype wire
